// [rtl/etc_pkg.sv]
// Shared constants for the eight-bit tick counter: register map, fields, resets and timing.
package etc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets on the Wishbone slave.
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OPTION = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h0c;

  // Option register fields.
  localparam int OPT_W         = 6;
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_RATIO_W   = 3;
  localparam int OPT_BYPASS    = 3;
  localparam int OPT_EDGE      = 4;
  localparam int OPT_SOURCE    = 5;

  // Status and mask fields.
  localparam int STAT_W    = 1;
  localparam int STAT_WRAP = 0;

  // Reset values.
  localparam logic [7:0]       COUNT_RESET  = 8'h00;
  localparam logic [OPT_W-1:0] OPTION_RESET = 6'h3f;
  localparam logic [STAT_W-1:0] STAT_RESET  = 1'h0;
  localparam logic [STAT_W-1:0] MASK_RESET  = 1'h0;
  localparam logic [7:0]       PRE_RESET    = 8'h00;

  // Timing: the instruction cycle is four clocks, quarter phases Q1 to Q4.
  localparam int CLK_HZ = 25_000_000;
  localparam int INSTR_CLOCKS = 4;
  localparam int PHASE_W = $clog2(INSTR_CLOCKS);
  localparam logic [PHASE_W-1:0] PHASE_Q2 = 2'h1;
  localparam logic [PHASE_W-1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

endpackage

// [rtl/etc_tick_counter.sv]
// Eight-bit timer/counter with prescaler, write inhibit, wrap flag and a Wishbone slave.

// Function
// [R1] One 8-bit software read/write count register serves timer and counter modes.
// [R2] An 8-bit prescaler belongs to this counter alone, not shared with watchdog.
// [R3] Software selects instruction clock or external input pin as count source.
// [R4] Software selects rising or falling edge of the external input.
// [R5] Timer mode without prescaler increments the count once per instruction cycle.
// [R6] Clearing the source-select bit puts the counter into timer mode.
// [R7] A count register write suppresses incrementing for two following instruction cycles.
// [R8] Software should adjust written values for the two-cycle suppression.
// [R9] The wrap event is exported as an output usable as a companion timer gate.
// [R10] Wrap from FFh to 00h sets a flag regardless of mask; software clears it.
// [R11] Eight ratios 1:2 to 1:256, bypass gives 1:1, count write clears prescaler.
// [R12] In counter mode prescaler output is sampled on Q2 and Q4 before incrementing.
// [R13] During sleep counting stops and the count register holds its value.
// [R14] After wrapping the count continues from zero without software action.
module etc_tick_counter (
  input  wire  logic                        clk,
  input  wire  logic                        reset_n,
  input  wire  logic                        wb_cyc_i,
  input  wire  logic                        wb_stb_i,
  input  wire  logic                        wb_we_i,
  input  wire  logic [etc_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire  logic [etc_pkg::DATA_W/8-1:0] wb_sel_i,
  input  wire  logic [etc_pkg::DATA_W-1:0]  wb_dat_i,
  output logic       [etc_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire  logic                        external_count_input,
  input  wire  logic                        sleepActive,
  output logic                              wrapOut,
  output logic                              irq
);
  import etc_pkg::*;

  logic [1:0]         rstPipe;
  logic               rstN;
  logic               busReq;
  logic               wrEn;
  logic               countWrite;
  logic [DATA_W-1:0]  readMux;
  logic [PHASE_W-1:0] phase;
  logic               instrTick;
  logic               sampleQ;
  logic [2:0]         extSync;
  logic               extLevel;
  logic               extAgree;
  logic               extRise;
  logic               extFall;
  logic               extEdge;
  logic               sourceEvent;
  logic [7:0]         prescaler;
  logic [7:0]         ratioMask;
  logic               preEvent;
  logic               pending;
  logic               incReq;
  logic               doInc;
  logic               wrap;
  logic [1:0]         inhibit;
  logic [7:0]         tick_count_value;
  logic [OPT_W-1:0]   option;
  logic [STAT_W-1:0]  status;
  logic [STAT_W-1:0]  mask;
  logic               count_source_select;
  logic               count_edge_select;
  logic               prescaler_bypass;
  logic [OPT_RATIO_W-1:0] prescale_ratio_field;

  assign count_source_select  = option[OPT_SOURCE];
  assign count_edge_select    = option[OPT_EDGE];
  assign prescaler_bypass     = option[OPT_BYPASS];
  assign prescale_ratio_field = option[OPT_RATIO_LSB +: OPT_RATIO_W];

  //////////////////////////////////////////////////////////////////////////////
  // Reset release.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstN = rstPipe[1];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for every address, unmapped reads zero.

  assign busReq     = wb_cyc_i & wb_stb_i;
  assign wrEn       = busReq & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign countWrite = wrEn & (wb_adr_i == OFS_COUNT);

  always_comb begin
    readMux = '0;
    unique case (wb_adr_i)
      OFS_COUNT:  readMux[7:0]        = tick_count_value;
      OFS_OPTION: readMux[OPT_W-1:0]  = option;
      OFS_STATUS: readMux[STAT_W-1:0] = status;
      OFS_MASK:   readMux[STAT_W-1:0] = mask;
      default:    readMux             = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wb_dat_o <= '0;
    end else if (busReq & ~wb_ack_o) begin
      wb_dat_o <= readMux;
    end else begin
      wb_dat_o <= '0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      option <= OPTION_RESET;
    end else if (wrEn & (wb_adr_i == OFS_OPTION)) begin
      option <= wb_dat_i[OPT_W-1:0];
    end
  end

  chk_ack_single: assert property (@(posedge clk) disable iff (!rstN)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");

  chk_ack_answer: assert property (@(posedge clk) disable iff (!rstN)
    (busReq && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered after one wait state");

  //////////////////////////////////////////////////////////////////////////////
  // Instruction cycle phases: Q4 ends each cycle.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      phase <= '0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign instrTick = (phase == PHASE_Q4);
  assign sampleQ   = ((phase == PHASE_Q2) | (phase == PHASE_Q4)) & ~sleepActive; // [R12]

  //////////////////////////////////////////////////////////////////////////////
  // External input: three stages, a change counts once stages two and three agree.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      extSync <= 3'h0;
    end else begin
      extSync <= {extSync[1:0], external_count_input};
    end
  end

  assign extAgree = (extSync[1] == extSync[2]);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      extLevel <= 1'b0;
    end else if (extAgree) begin
      extLevel <= extSync[2];
    end
  end

  assign extRise = extAgree & extSync[2] & ~extLevel;
  assign extFall = extAgree & ~extSync[2] & extLevel;
  assign extEdge = count_edge_select ? extFall : extRise; // [R4]

  // Sleep freezes the source, so the prescaler holds as well.
  assign sourceEvent = ~sleepActive & (count_source_select ? extEdge : instrTick); // [R3] [R6] [R13]

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler: private to this counter, cleared by any count write.

  assign ratioMask = 8'((9'h002 << prescale_ratio_field) - 9'h001); // [R11]

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prescaler <= PRE_RESET;
    end else if (countWrite) begin
      prescaler <= PRE_RESET; // [R11]
    end else if (sourceEvent & ~prescaler_bypass) begin
      prescaler <= prescaler + 8'h01; // [R2]
    end
  end

  assign preEvent = sourceEvent &
                    (prescaler_bypass | ((prescaler & ratioMask) == ratioMask)); // [R11]

  chk_presc_clear: assert property (@(posedge clk) disable iff (!rstN) // [R11]
    countWrite |=> (prescaler == PRE_RESET)) // [R11]
    else $error("prescaler not cleared by count write");

  chk_prescale_gate: assert property (@(posedge clk) disable iff (!rstN) // [R11]
    (!count_source_select && !prescaler_bypass && instrTick && !countWrite
      && ((prescaler & ratioMask) != ratioMask)) |=> $stable(tick_count_value))
    else $error("prescaler passed an event early");

  //////////////////////////////////////////////////////////////////////////////
  // Counter-mode sampling of the prescaler output on Q2 and Q4.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pending <= 1'b0;
    end else if (countWrite) begin
      pending <= 1'b0;
    end else if (preEvent & count_source_select) begin
      pending <= 1'b1; // [R12]
    end else if (sampleQ) begin
      pending <= 1'b0; // [R12]
    end
  end

  assign incReq = count_source_select ? (pending & sampleQ) : preEvent; // [R5] [R12]

  //////////////////////////////////////////////////////////////////////////////
  // Write inhibit: two instruction cycles after every count write.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inhibit <= 2'h0;
    end else if (countWrite) begin
      inhibit <= INHIBIT_CYCLES; // [R7]
    end else if (instrTick & ~sleepActive & (inhibit != 2'h0)) begin
      inhibit <= inhibit - 2'h1; // [R7]
    end
  end

  assign doInc = incReq & (inhibit == 2'h0) & ~sleepActive; // [R7] [R13]
  assign wrap  = doInc & (tick_count_value == 8'hff);

  chk_inhibit_hold: assert property (@(posedge clk) disable iff (!rstN) // [R7]
    ((inhibit != 2'h0) && !countWrite) |=> $stable(tick_count_value)) // [R7]
    else $error("count moved during write inhibit");

  chk_inhibit_span: assert property (@(posedge clk) disable iff (!rstN) // [R7]
    (countWrite && !sleepActive) |=> (inhibit == INHIBIT_CYCLES)[*1]
      ##0 (inhibit != 2'h0)[*4]) // [R7]
    else $error("inhibit shorter than two instruction cycles");

  //////////////////////////////////////////////////////////////////////////////
  // Count register.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tick_count_value <= COUNT_RESET;
    end else if (countWrite) begin
      tick_count_value <= wb_dat_i[7:0]; // [R1]
    end else if (doInc) begin
      tick_count_value <= tick_count_value + 8'h01; // [R1] [R5] [R14]
    end
  end

  chk_write_loads: assert property (@(posedge clk) disable iff (!rstN) // [R1]
    countWrite |=> (tick_count_value == $past(wb_dat_i[7:0]))) // [R1]
    else $error("count write not loaded");

  chk_timer_rate: assert property (@(posedge clk) disable iff (!rstN) // [R5]
    (!count_source_select && prescaler_bypass && instrTick && (inhibit == 2'h0)
      && !sleepActive && !countWrite)
    |=> (tick_count_value == 8'($past(tick_count_value) + 8'h01))) // [R5]
    else $error("timer mode missed an instruction cycle");

  chk_sleep_freeze: assert property (@(posedge clk) disable iff (!rstN) // [R13]
    (sleepActive && !countWrite) |=> $stable(tick_count_value)) // [R13]
    else $error("count changed during sleep");

  chk_ext_sample: assert property (@(posedge clk) disable iff (!rstN) // [R12]
    (count_source_select && !countWrite && (phase != PHASE_Q2) && (phase != PHASE_Q4))
    |=> $stable(tick_count_value)) // [R12]
    else $error("counter mode increment outside Q2 or Q4");

  chk_wrap_zero: assert property (@(posedge clk) disable iff (!rstN) // [R14]
    (wrap && !countWrite) |=> (tick_count_value == 8'h00)) // [R14]
    else $error("wrap did not continue from zero");

  //////////////////////////////////////////////////////////////////////////////
  // Wrap output, sticky flag with write-one-to-clear, mask and interrupt.

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrapOut <= 1'b0;
    end else begin
      wrapOut <= wrap; // [R9]
    end
  end

  // A wrap in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      status <= STAT_RESET;
    end else if (wrap) begin
      status[STAT_WRAP] <= 1'b1; // [R10]
    end else if (wrEn & (wb_adr_i == OFS_STATUS)) begin
      status <= status & ~wb_dat_i[STAT_W-1:0]; // [R10]
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mask <= MASK_RESET;
    end else if (wrEn & (wb_adr_i == OFS_MASK)) begin
      mask <= wb_dat_i[STAT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  chk_wrap_flag: assert property (@(posedge clk) disable iff (!rstN) // [R10]
    wrap |=> status[STAT_WRAP]) // [R10]
    else $error("wrap flag not set on overflow");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstN) // [R10]
    (status[STAT_WRAP] && !(wrEn && (wb_adr_i == OFS_STATUS))) |=> status[STAT_WRAP]) // [R10]
    else $error("wrap flag cleared without a write");

  chk_wrap_out: assert property (@(posedge clk) disable iff (!rstN) // [R9]
    wrap |=> wrapOut ##1 !wrapOut) // [R9]
    else $error("wrap output not a single pulse");

  chk_irq_level: assert property (@(posedge clk) disable iff (!rstN)
    |(status & mask) |=> irq)
    else $error("interrupt missing for unmasked flag");

  chk_irq_clear: assert property (@(posedge clk) disable iff (!rstN)
    !(|(status & mask)) |=> !irq)
    else $error("interrupt stood without an unmasked flag");

endmodule

// [verif/etc_pulse_src.sv]
// Pulse source model that drives the external count pin.
module etc_pulse_src (
  input  wire logic       clk,
  input  wire logic       idleLvl,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left = 5'h00;
  logic [1:0] ph   = 2'h0;
  // Each pulse holds the idle level for four clocks, then leaves it for four.
  assign busy = left != 5'h00;
  assign pin  = idleLvl ^ left[0];
  always_ff @(posedge clk) begin
    ph <= ph + 2'h1;
    if (go && !busy) begin
      left <= {pulses, 1'b0};
      ph   <= 2'h0;
    end else if (busy && ph == 2'h3) begin
      left <= left - 5'h01;
    end
  end
endmodule

// [verif/tb.sv]
// Self-checking bench for the eight-bit tick counter.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import etc_pkg::*;
  logic              clk = 1'b0;
  logic              resetN = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0]        sel = 4'h1;
  logic [3:0]        busSel = 4'h1;
  logic [DATA_W-1:0] dat = 32'h0;
  logic [DATA_W-1:0] rdat;
  logic              ack;
  logic              sleep = 1'b0;
  logic              idle = 1'b0;
  logic              go = 1'b0;
  logic [3:0]        pulses = 4'h0;
  logic              pin;
  logic              busy;
  logic              wrap;
  logic              irq;
  int                cycNo = 0;
  int                errorCnt = 0;
  int                checkCount = 0;
  ////////////////////////////////////////
  always #20 clk = ~clk;
  always @(negedge clk) cycNo++;
  etc_tick_counter u_etc_tick_counter (
    .clk(clk), .reset_n(resetN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_input(pin), .sleepActive(sleep), .wrapOut(wrap), .irq(irq));
  etc_pulse_src u_etc_pulse_src (
    .clk(clk), .idleLvl(idle), .go(go), .pulses(pulses), .pin(pin), .busy(busy));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= busSel;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  // Two reads of identical shape spaced w clocks apart give the exact count.
  task automatic rate(input int w, input logic [7:0] e, input string n);
    int t0;
    logic [31:0] a;
    logic [31:0] b;
    t0 = cycNo;
    bus(1'b0, OFS_COUNT, 32'h0, a);
    while (cycNo < t0 + w) @(posedge clk);
    bus(1'b0, OFS_COUNT, 32'h0, b);
    chk(n, {24'h0, e}, {24'h0, b[7:0] - a[7:0]});
  endtask
  task automatic pulse(input logic [3:0] n);
    @(posedge clk);
    pulses <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask
  task automatic lvl(input logic v);
    idle <= v;
    repeat (12) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic s_reset();
    rdc(OFS_COUNT, 32'h00, "count");
    rdc(OFS_OPTION, 32'h3f, "option");
    rdc(OFS_STATUS, 32'h0, "status");
    rdc(OFS_MASK, 32'h0, "mask");
    rdc(8'h10, 32'h0, "unmapped");
    busSel = 4'h0;
    wr(OFS_MASK, 32'h1);
    busSel = 4'h1;
    rdc(OFS_MASK, 32'h0, "maskSel0");
    wr(8'h10, 32'hff);
    rdc(8'h10, 32'h0, "unmappedWr");
  endtask
  task automatic s_timer();
    wr(OFS_OPTION, 32'h08);
    wr(OFS_COUNT, 32'h40);
    rdc(OFS_COUNT, 32'h40, "held1");
    rdc(OFS_COUNT, 32'h40, "held2");
    rate(40, 8'd10, "timer");
    sleep <= 1'b1;
    rate(40, 8'd0, "sleep");
    sleep <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      wr(OFS_OPTION, r);
      rate(16 << r, 8'd2, "ratio");
    end
  endtask
  task automatic s_wrap();
    int k;
    wr(OFS_OPTION, 32'h08);
    wr(OFS_COUNT, 32'hfe);
    k = 0;
    while (wrap !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("wrapOut", 32'h1, {31'h0, wrap});
    rdc(OFS_STATUS, 32'h1, "flag");
    chk("irqMasked", 32'h0, {31'h0, irq});
    rate(40, 8'd10, "after");
    wr(OFS_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqOn", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqOff", 32'h0, {31'h0, irq});
    rdc(OFS_STATUS, 32'h0, "cleared");
  endtask
  task automatic s_counter();
    wr(OFS_OPTION, 32'h28);
    wr(OFS_COUNT, 32'h00);
    pulse(4'd5);
    rdc(OFS_COUNT, 32'h05, "pins");
    lvl(1'b1);
    rdc(OFS_COUNT, 32'h06, "rise");
    wr(OFS_OPTION, 32'h38);
    lvl(1'b0);
    rdc(OFS_COUNT, 32'h07, "fall");
    lvl(1'b1);
    rdc(OFS_COUNT, 32'h07, "noRise");
    lvl(1'b0);
    wr(OFS_OPTION, 32'h20);
    pulse(4'd1);
    wr(OFS_COUNT, 32'h00);
    pulse(4'd1);
    rdc(OFS_COUNT, 32'h00, "preClr");
    pulse(4'd1);
    rdc(OFS_COUNT, 32'h01, "preDiv");
  endtask
  ////////////////////////////////////////
  task automatic endSim();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 40);
    errorCnt++;
    endSim();
  end
  initial begin
    repeat (6) @(posedge clk);
    resetN <= 1'b1;
    repeat (3) @(posedge clk);
    s_reset();
    s_timer();
    s_wrap();
    s_counter();
    endSim();
  end
endmodule
